// ### secu_alu.sv
package secu_pkg;
    localparam int PC_W          = 15;
    localparam int DATA_W        = 8;
    localparam int FADDR_W       = 7;
    localparam int LIT_W         = 11;
    localparam int LATCH_W       = 7;
    localparam int BSEL_W        = 3;
    localparam int CALL_LO_W     = 11;
    localparam int INDIRECT_SUBROUTINE_CALL_LO_W    = 8;
    localparam int LATCH_HI      = 6;
    localparam int LATCH_CALL_LO = 3;
    localparam logic [PC_W-1:0]    PC_RST     = 15'h0000;
    localparam logic [PC_W-1:0]    PC_STEP    = 15'h0001;
    localparam logic [DATA_W-1:0]  W_RST      = 8'h00;
    localparam logic [DATA_W-1:0]  DATA_ZERO  = 8'h00;
    localparam logic [DATA_W-1:0]  DATA_ONE   = 8'h01;
    localparam logic               Z_RST      = 1'b0;
    localparam logic               TO_N_RST   = 1'b1;
    localparam logic               PD_N_RST   = 1'b1;
    localparam logic               DEST_W     = 1'b0;
    localparam logic               DEST_F     = 1'b1;

    typedef enum logic [3:0] {
        SECU_NOP      = 4'h0,
        SECU_BTFS_SET = 4'h1,
        SECU_CALL_LIT = 4'h2,
        SECU_CALL_W   = 4'h3,
        SECU_CLR_FILE = 4'h4,
        SECU_CLR_W    = 4'h5,
        SECU_CLR_WDOG = 4'h6,
        SECU_COMP     = 4'h7,
        SECU_DEC      = 4'h8
    } secu_op_t;

    typedef enum logic [0:0] {
        SECU_RUN   = 1'b0,
        SECU_FLUSH = 1'b1
    } secu_state_t;
endpackage

module secu_alu
    import secu_pkg::*;
(
    input  wire secu_pkg::secu_op_t          op_in,
    input  wire logic [secu_pkg::DATA_W-1:0] operand_in,
    output logic      [secu_pkg::DATA_W-1:0] result_out,
    output logic                             zero_out
);
    always_comb
    begin
        case (op_in)
            SECU_COMP: result_out = ~operand_in;
            SECU_DEC:  result_out = operand_in - DATA_ONE;
            default:   result_out = DATA_ZERO;
        endcase
        zero_out = (result_out == DATA_ZERO);
    end
endmodule

// ### secu_exec.sv
module secu_exec
    import secu_pkg::*;
(
    input  wire logic                               clock_in,
    input  wire logic                               rst_n_in,
    input  wire logic                               instr_valid_in,
    input  wire secu_pkg::secu_op_t                 op_in,
    input  wire logic [secu_pkg::FADDR_W-1:0]       faddr_in,
    input  wire logic [secu_pkg::BSEL_W-1:0]        bit_sel_in,
    input  wire logic                               dest_in,
    input  wire logic [secu_pkg::LIT_W-1:0]         literal_in,
    input  wire logic [secu_pkg::DATA_W-1:0]        file_rdata_in,
    input  wire logic [secu_pkg::LATCH_W-1:0]       pc_page_latch_in,
    output logic                                    instr_ready_out,
    output logic                                    discard_out,
    output logic [secu_pkg::PC_W-1:0]               pc_out,
    output logic [secu_pkg::DATA_W-1:0]             w_out,
    output logic                                    zero_flag_out,
    output logic                                    timeout_status_n_out,
    output logic                                    powerdown_status_n_out,
    output logic                                    file_we_out,
    output logic [secu_pkg::FADDR_W-1:0]            file_waddr_out,
    output logic [secu_pkg::DATA_W-1:0]             file_wdata_out,
    output logic                                    stack_push_out,
    output logic [secu_pkg::PC_W-1:0]               return_stack_top_out,
    output logic                                    watchdog_clear_out,
    output logic                                    prescaler_clear_out
);
    import secu_pkg::*;

    secu_state_t               state_reg;
    secu_state_t               state_next;
    logic [PC_W-1:0]           pc_reg;
    logic [PC_W-1:0]           pc_next;
    logic [PC_W-1:0]           pc_plus_one;
    logic [DATA_W-1:0]         w_reg;
    logic                      zero_reg;
    logic                      to_n_reg;
    logic                      pd_n_reg;
    logic                      ready_reg;
    logic                      discard_reg;
    logic                      file_we_reg;
    logic [FADDR_W-1:0]        file_waddr_reg;
    logic [DATA_W-1:0]         file_wdata_reg;
    logic                      push_reg;
    logic [PC_W-1:0]           tos_reg;
    logic                      wdt_clr_reg;
    logic                      pre_clr_reg;
    logic                      exec_now;
    logic                      bit_is_set;
    logic                      two_cycle;
    logic [DATA_W-1:0]         alu_result;
    logic                      alu_zero;
    logic                      call_now;
    logic                      clr_wdog_now;

    secu_alu u_alu
    (
        .op_in      (op_in),
        .operand_in (file_rdata_in),
        .result_out (alu_result),
        .zero_out   (alu_zero)
    );

    assign exec_now    = instr_valid_in && (state_reg == SECU_RUN);
    assign bit_is_set  = file_rdata_in[bit_sel_in];
    assign pc_plus_one = pc_reg + PC_STEP;
    assign call_now     = exec_now && ((op_in == SECU_CALL_LIT) || (op_in == SECU_CALL_W));
    assign clr_wdog_now = exec_now && (op_in == SECU_CLR_WDOG);

    // Which instructions hold the core for a second cycle
    always_comb
    begin
        case (op_in)
            SECU_BTFS_SET: two_cycle = bit_is_set;
            SECU_CALL_LIT: two_cycle = 1'b1;
            SECU_CALL_W:   two_cycle = 1'b1;
            default:       two_cycle = 1'b0;
        endcase
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SECU_RUN:
            begin
                if (exec_now && two_cycle)
                begin
                    state_next = SECU_FLUSH;
                end
            end
            SECU_FLUSH:
            begin
                state_next = SECU_RUN;
            end
            default:
            begin
                state_next = SECU_RUN;
            end
        endcase
    end

    // Program counter target
    always_comb
    begin
        pc_next = pc_reg;
        if (state_reg == SECU_FLUSH)
        begin
            pc_next = pc_plus_one;
        end
        else if (exec_now)
        begin
            case (op_in)
                SECU_CALL_LIT:
                begin
                    pc_next = {pc_page_latch_in[LATCH_HI:LATCH_CALL_LO],
                               literal_in[CALL_LO_W-1:0]};
                end
                SECU_CALL_W:
                begin
                    pc_next = {pc_page_latch_in, w_reg[INDIRECT_SUBROUTINE_CALL_LO_W-1:0]};
                end
                default:
                begin
                    pc_next = pc_plus_one;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg   <= SECU_RUN;
            ready_reg   <= 1'b1;
            discard_reg <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            ready_reg   <= (state_next == SECU_RUN);
            discard_reg <= (state_next == SECU_FLUSH);
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pc_reg <= PC_RST;
        end
        else
        begin
            pc_reg <= pc_next;
        end
    end

    // Return stack push
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            push_reg <= 1'b0;
            tos_reg  <= PC_RST;
        end
        else
        begin
            push_reg <= call_now;
            if (call_now)
            begin
                tos_reg <= pc_plus_one;
            end
        end
    end

    // Working register
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            w_reg <= W_RST;
        end
        else if (exec_now)
        begin
            case (op_in)
                SECU_CLR_W:
                begin
                    w_reg <= DATA_ZERO;
                end
                SECU_COMP, SECU_DEC:
                begin
                    if (dest_in == DEST_W)
                    begin
                        w_reg <= alu_result;
                    end
                end
                default:
                begin
                    w_reg <= w_reg;
                end
            endcase
        end
    end

    // Zero flag, held by instructions that do not affect it
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            zero_reg <= Z_RST;
        end
        else if (exec_now)
        begin
            case (op_in)
                SECU_CLR_FILE, SECU_CLR_W:
                begin
                    zero_reg <= 1'b1;
                end
                SECU_COMP, SECU_DEC:
                begin
                    zero_reg <= alu_zero;
                end
                default:
                begin
                    zero_reg <= zero_reg;
                end
            endcase
        end
    end

    // File register write port
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            file_we_reg    <= 1'b0;
            file_waddr_reg <= {FADDR_W{1'b0}};
            file_wdata_reg <= DATA_ZERO;
        end
        else
        begin
            file_we_reg    <= 1'b0;
            file_waddr_reg <= faddr_in;
            if (exec_now && (op_in == SECU_CLR_FILE))
            begin
                file_we_reg    <= 1'b1;
                file_wdata_reg <= DATA_ZERO;
            end
            else if (exec_now && ((op_in == SECU_COMP) || (op_in == SECU_DEC)) && (dest_in == DEST_F))
            begin
                file_we_reg    <= 1'b1;
                file_wdata_reg <= alu_result;
            end
        end
    end

    // Watchdog and prescaler clear pulses
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wdt_clr_reg <= 1'b0;
            pre_clr_reg <= 1'b0;
        end
        else
        begin
            wdt_clr_reg <= clr_wdog_now;
            pre_clr_reg <= clr_wdog_now;
        end
    end

    // Active-low time-out and power-down status bits
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            to_n_reg <= TO_N_RST;
            pd_n_reg <= PD_N_RST;
        end
        else if (clr_wdog_now)
        begin
            to_n_reg <= 1'b1;
            pd_n_reg <= 1'b1;
        end
    end

    assign instr_ready_out        = ready_reg;
    assign discard_out            = discard_reg;
    assign pc_out                 = pc_reg;
    assign w_out                  = w_reg;
    assign zero_flag_out          = zero_reg;
    assign timeout_status_n_out   = to_n_reg;
    assign powerdown_status_n_out = pd_n_reg;
    assign file_we_out            = file_we_reg;
    assign file_waddr_out         = file_waddr_reg;
    assign file_wdata_out         = file_wdata_reg;
    assign stack_push_out         = push_reg;
    assign return_stack_top_out   = tos_reg;
    assign watchdog_clear_out     = wdt_clr_reg;
    assign prescaler_clear_out    = pre_clr_reg;
endmodule

// ### secu_exec_props.sv
module secu_exec_props
    import secu_pkg::*;
(
    input wire logic                clock_in,
    input wire logic                rst_n_in,
    input wire logic                instr_valid_in,
    input wire secu_pkg::secu_op_t  op_in,
    input wire logic [2:0]          bit_sel_in,
    input wire logic                dest_in,
    input wire logic [10:0]         literal_in,
    input wire logic [7:0]          file_rdata_in,
    input wire logic [6:0]          pc_page_latch_in,
    input wire logic                instr_ready_out,
    input wire logic                discard_out,
    input wire logic [14:0]         pc_out,
    input wire logic [7:0]          w_out,
    input wire logic                zero_flag_out,
    input wire logic                timeout_status_n_out,
    input wire logic                powerdown_status_n_out,
    input wire logic                file_we_out,
    input wire logic [7:0]          file_wdata_out,
    input wire logic                stack_push_out,
    input wire logic [14:0]         return_stack_top_out,
    input wire logic                watchdog_clear_out,
    input wire logic                prescaler_clear_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    wire logic tk;
    assign tk = instr_valid_in && instr_ready_out;
    AST_SKIP: assert property (tk && op_in == SECU_BTFS_SET && file_rdata_in[bit_sel_in]
        |=> discard_out && !instr_ready_out ##1 instr_ready_out) else $error("skip missing");
    AST_NOSKIP: assert property (tk && op_in == SECU_BTFS_SET && !file_rdata_in[bit_sel_in]
        |=> instr_ready_out && !discard_out) else $error("unexpected skip");
    AST_CALL: assert property (tk && op_in == SECU_CALL_LIT |=> stack_push_out
        && return_stack_top_out == $past(pc_out) + 15'h0001 && pc_out[10:0] == $past(literal_in)
        && pc_out[14:11] == ($past(pc_page_latch_in) >> 3)) else $error("literal call wrong");
    AST_CALL_LEN: assert property (tk && (op_in == SECU_CALL_LIT || op_in == SECU_CALL_W)
        |=> discard_out ##1 instr_ready_out && !discard_out) else $error("call length wrong");
    AST_INDIRECT_SUBROUTINE_CALL: assert property (tk && op_in == SECU_CALL_W |=> stack_push_out
        && return_stack_top_out == $past(pc_out) + 15'h0001
        && pc_out == {$past(pc_page_latch_in), $past(w_out)}) else $error("indirect call wrong");
    AST_CLEAR_FILE_REG_OP: assert property (tk && op_in == SECU_CLR_FILE
        |=> file_we_out && file_wdata_out == 8'h00 && zero_flag_out) else $error("clear file wrong");
    AST_CLEAR_WORKING_OP: assert property (tk && op_in == SECU_CLR_W |=> w_out == 8'h00 && zero_flag_out)
        else $error("clear w wrong");
    AST_WDOG: assert property (tk && op_in == SECU_CLR_WDOG |=> watchdog_clear_out && prescaler_clear_out
        && timeout_status_n_out && powerdown_status_n_out) else $error("watchdog clear wrong");
    AST_COMP: assert property (tk && op_in == SECU_COMP && dest_in |=> file_we_out
        && file_wdata_out == ~$past(file_rdata_in)
        && zero_flag_out == ($past(file_rdata_in) == 8'hff)) else $error("complement wrong");
    AST_DEC: assert property (tk && op_in == SECU_DEC && !dest_in |=> !file_we_out
        && w_out == $past(file_rdata_in) - 8'h01
        && zero_flag_out == ($past(file_rdata_in) == 8'h01)) else $error("decrement wrong");
    cover property (tk && op_in == SECU_BTFS_SET && file_rdata_in[bit_sel_in]);
    cover property (tk && op_in == SECU_CALL_W);
    cover property (tk && op_in == SECU_DEC && file_rdata_in == 8'h01);
endmodule

// ### testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import secu_pkg::*;
    logic           clock_in = 1'b0;
    logic           rst_n_in = 1'b0;
    logic           instr_valid_in = 1'b0;
    secu_op_t       op_in = SECU_NOP;
    logic [6:0]     faddr_in = 7'h00;
    logic [2:0]     bit_sel_in = 3'h0;
    logic           dest_in = 1'b0;
    logic [10:0]    literal_in = 11'h000;
    logic [7:0]     file_rdata_in = 8'h00;
    logic [6:0]     pc_page_latch_in = 7'h00;
    logic           instr_ready_out, discard_out, zero_flag_out, file_we_out, stack_push_out;
    logic           timeout_status_n_out, powerdown_status_n_out, watchdog_clear_out, prescaler_clear_out;
    logic [14:0]    pc_out, return_stack_top_out, m_pc, m_tos;
    logic [7:0]     w_out, file_wdata_out, m_w, m_wd, r;
    logic [6:0]     file_waddr_out, m_wa;
    logic           m_z, m_fl, m_push, m_we, m_clr;
    logic [15:0]    lfsr = 16'h0017;
    int             miscompares = 0;
    int             checked = 0;
    int             cycles = 0;
    secu_exec u_secu_exec (.clock_in, .rst_n_in, .instr_valid_in, .op_in, .faddr_in, .bit_sel_in, .dest_in,
        .literal_in, .file_rdata_in, .pc_page_latch_in, .instr_ready_out, .discard_out, .pc_out, .w_out,
        .zero_flag_out, .timeout_status_n_out, .powerdown_status_n_out, .file_we_out, .file_waddr_out,
        .file_wdata_out, .stack_push_out, .return_stack_top_out, .watchdog_clear_out, .prescaler_clear_out);
    always #2 clock_in = ~clock_in;
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task summarize();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Reference model of the execution unit
    always @(posedge clock_in or negedge rst_n_in)
    begin
        m_push = 1'b0;
        m_we = 1'b0;
        m_clr = 1'b0;
        r = (op_in == SECU_COMP) ? ~file_rdata_in : file_rdata_in - 8'h01;
        if (!rst_n_in)
        begin
            m_pc = 15'h0000;
            m_w = 8'h00;
            m_z = 1'b0;
            m_fl = 1'b0;
        end
        else if (m_fl)
        begin
            m_fl = 1'b0;
            m_pc = m_pc + 15'h0001;
        end
        else if (instr_valid_in)
        begin
            m_pc = m_pc + 15'h0001;
            m_wa = faddr_in;
            case (op_in)
                SECU_BTFS_SET: m_fl = file_rdata_in[bit_sel_in];
                SECU_CALL_LIT, SECU_CALL_W:
                begin
                    m_push = 1'b1;
                    m_tos = m_pc;
                    m_fl = 1'b1;
                    m_pc = (op_in == SECU_CALL_W) ? {pc_page_latch_in, m_w}
                                                  : {pc_page_latch_in[6:3], literal_in};
                end
                SECU_CLR_FILE:
                begin
                    m_we = 1'b1;
                    m_wd = 8'h00;
                    m_z = 1'b1;
                end
                SECU_CLR_W:
                begin
                    m_w = 8'h00;
                    m_z = 1'b1;
                end
                SECU_CLR_WDOG: m_clr = 1'b1;
                SECU_COMP, SECU_DEC:
                begin
                    m_we = dest_in;
                    m_wd = r;
                    if (!dest_in)
                        m_w = r;
                    m_z = (r == 8'h00);
                end
                default: ;
            endcase
        end
    end
    // Outputs are compared where settled, half a cycle after each rising edge
    always @(negedge clock_in)
    begin
        cycles++;
        if (cycles > 4000)
        begin
            miscompares++;
            summarize();
        end
        else if (rst_n_in)
        begin
            check(pc_out, m_pc);
            check(w_out, m_w);
            check(zero_flag_out, m_z);
            check(instr_ready_out, !m_fl);
            check(discard_out, m_fl);
            check(stack_push_out, m_push);
            if (m_push)
                check(return_stack_top_out, m_tos);
            check(file_we_out, m_we);
            if (m_we)
                check({file_waddr_out, file_wdata_out}, {m_wa, m_wd});
            check({watchdog_clear_out, prescaler_clear_out}, {2{m_clr}});
            check({timeout_status_n_out, powerdown_status_n_out}, 2'b11);
        end
    end
    // Random instruction stream with one reset in mid-run
    initial
    begin
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 3000; i++)
        begin
            @(posedge clock_in);
            lfsr = nxt(nxt(lfsr));
            instr_valid_in <= lfsr[0] | lfsr[1];
            op_in <= secu_op_t'(lfsr[15:8] % 9);
            faddr_in <= lfsr[6:0];
            bit_sel_in <= lfsr[9:7];
            dest_in <= lfsr[3];
            literal_in <= lfsr[12:2];
            pc_page_latch_in <= lfsr[14:8];
            file_rdata_in <= (lfsr[5:4] == 2'h0) ? {8{lfsr[6]}} : (lfsr[5:4] == 2'h1) ? 8'h01 : lfsr[13:6];
            rst_n_in <= (i != 1500);
        end
        summarize();
    end
endmodule
bind secu_exec secu_exec_props u_secu_exec_props (.clock_in, .rst_n_in, .instr_valid_in, .op_in, .bit_sel_in,
    .dest_in, .literal_in, .file_rdata_in, .pc_page_latch_in, .instr_ready_out, .discard_out, .pc_out, .w_out,
    .zero_flag_out, .timeout_status_n_out, .powerdown_status_n_out, .file_we_out, .file_wdata_out,
    .stack_push_out, .return_stack_top_out, .watchdog_clear_out, .prescaler_clear_out);
